// ### encl_pkg.sv
package encl_pkg;
   localparam int ADDR_W = 8;
   // register byte addresses
   localparam logic [7:0] ENCLOSURE_MSG_CONTROL_STATUS_OFS = 8'h20;
   localparam logic [7:0] EXTENDED_CAPABILITIES_OFS = 8'h24;
   localparam logic [7:0] INT_STS_OFS = 8'h30;
   localparam logic [7:0] INT_MSK_OFS = 8'h34;
   localparam logic [7:0] LINK_OFS = 8'h38;
   // enclosure control field positions
   localparam int SMB_BIT = 24;
   localparam int SGPIO_BIT = 19;
   localparam int SES2_BIT = 18;
   localparam int SAFTE_BIT = 17;
   localparam int LED_BIT = 16;
   localparam int RST_BIT = 9;
   localparam int TM_BIT = 8;
   localparam int MR_BIT = 0;
   // extended capability field positions
   localparam int AUTO_PARTIAL_TO_SLUMBER_CAP_BIT = 2;
   localparam int NV_CACHE_SUPPORT_CAP_BIT = 1;
   localparam int BOH_BIT = 0;
   // interrupt status layout
   localparam int IRQ_N = 3;
   localparam int IRQ_MR = 0;
   localparam int IRQ_TXDONE = 1;
   localparam int IRQ_RSTDONE = 2;
   // link status layout
   localparam int LNK_RST_BIT = 0;
   localparam int LNK_TX_BIT = 1;
   localparam int LNK_RX_BIT = 2;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
   // reset pulse length to the enclosure processor
   localparam int RST_TIME_NS = 1000;
   localparam int CLK_NS = 100;
   localparam int RST_CYC = (RST_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] RST_CYC_4 = 4'(RST_CYC);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RESET = 2'b01,
      ST_TX = 2'b10
   } em_state_e;

   typedef struct packed {
      logic smb;
      logic sgpio;
      logic ses2;
      logic safte;
      logic led;
      logic auto_partial_to_slumber_cap;
      logic nv_cache_support_cap;
      logic ownership_handoff_cap;
   } caps_s;

   typedef struct packed {
      em_state_e st;
      logic [3:0] cnt;
      logic rst_cmd;
      logic tx_cmd;
      logic mr;
      logic [IRQ_N-1:0] sts;
      logic [IRQ_N-1:0] msk;
      logic [31:0] rdata;
      logic irq;
      logic encl_rst;
      logic tx_start;
   } em_state_s;
endpackage

// ### enclosure_mgmt_control_caps.sv
`timescale 1ns/10ps
// Function
// RULE_01: the shared-buffer bit reports one buffer for send and receive.
// RULE_02: a read-only bit reports sgpio message support.
// RULE_03: a read-only bit reports ses-2 message support.
// RULE_04: a read-only bit reports saf-te message support.
// RULE_05: a read-only bit reports led message support.
// RULE_06: writing 1 to the reset command resets message logic and enclosure.
// RULE_07: the reset command self-clears when done; writing 0 does nothing.
// RULE_08: writing 1 to the transmit command sends the buffered message.
// RULE_09: transmit command clears when sent; writing 0 is ignored.
// RULE_10: software keeps the buffer unchanged while transmit reads 1.
// RULE_11: the received flag sets once a full message is buffered.
// RULE_12: software clears the received flag by writing 1; 0 is ignored.
// RULE_13: software should read the message before clearing the flag.
// RULE_14: a read-only bit reports auto partial-to-slumber support.
// RULE_15: a read-only bit reports cache support, range 60h-9fh valid.
// RULE_16: a read-only bit reports ownership handoff support.
// RULE_17: reserved bits read zero and ignore writes.
module enclosure_mgmt_control_caps #(
   parameter logic SMB = 1'b0,
   parameter logic SGPIO = 1'b0,
   parameter logic SES2 = 1'b0,
   parameter logic SAFTE = 1'b0,
   parameter logic LED = 1'b1,
   parameter logic AUTO_PARTIAL_TO_SLUMBER_CAP = 1'b0,
   parameter logic NV_CACHE_SUPPORT_CAP = 1'b0,
   parameter logic OWNERSHIP_HANDOFF_CAP = 1'b0
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic [encl_pkg::ADDR_W-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   output logic irq_o,
   output logic encl_rst_o,
   output logic tx_start_o,
   input wire logic tx_done_i,
   input wire logic rx_done_i
);

   ////////////////////////////////////////////////////////////////////////////
   encl_pkg::caps_s caps;
   encl_pkg::em_state_s s_r;
   encl_pkg::em_state_s s_nxt;
   logic wr_ctl;
   logic wr_sts;
   logic wr_msk;
   logic [encl_pkg::IRQ_N-1:0] ev;

   assign caps = '{SMB, SGPIO, SES2, SAFTE, LED, AUTO_PARTIAL_TO_SLUMBER_CAP, NV_CACHE_SUPPORT_CAP, OWNERSHIP_HANDOFF_CAP};

   function automatic logic [31:0] ctl_word(input encl_pkg::em_state_s s,
                                            input encl_pkg::caps_s c);
      logic [31:0] w;
      w = encl_pkg::ZERO32; // see RULE_17
      w[encl_pkg::SMB_BIT] = c.smb; // see RULE_01
      w[encl_pkg::SGPIO_BIT] = c.sgpio; // see RULE_02
      w[encl_pkg::SES2_BIT] = c.ses2; // see RULE_03
      w[encl_pkg::SAFTE_BIT] = c.safte; // see RULE_04
      w[encl_pkg::LED_BIT] = c.led; // see RULE_05
      w[encl_pkg::RST_BIT] = s.rst_cmd;
      w[encl_pkg::TM_BIT] = s.tx_cmd;
      w[encl_pkg::MR_BIT] = s.mr;
      return w;
   endfunction

   function automatic logic [31:0] extended_capabilities_word(input encl_pkg::caps_s c);
      logic [31:0] w;
      w = encl_pkg::ZERO32; // see RULE_17
      w[encl_pkg::AUTO_PARTIAL_TO_SLUMBER_CAP_BIT] = c.auto_partial_to_slumber_cap; // see RULE_14
      w[encl_pkg::NV_CACHE_SUPPORT_CAP_BIT] = c.nv_cache_support_cap; // see RULE_15
      w[encl_pkg::BOH_BIT] = c.ownership_handoff_cap; // see RULE_16
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   assign wr_ctl = wr_i && (addr_i == encl_pkg::ENCLOSURE_MSG_CONTROL_STATUS_OFS);
   assign wr_sts = wr_i && (addr_i == encl_pkg::INT_STS_OFS);
   assign wr_msk = wr_i && (addr_i == encl_pkg::INT_MSK_OFS);

   always_comb
   begin
      s_nxt = s_r;
      ev = '0;
      s_nxt.tx_start = 1'b0;
      unique case (s_r.st)
         encl_pkg::ST_IDLE:
         begin
            // reset outranks transmit when both are written together
            if (wr_ctl && wdata_i[encl_pkg::RST_BIT])
            begin
               s_nxt.rst_cmd = 1'b1; // see RULE_06
               s_nxt.tx_cmd = 1'b0;
               s_nxt.cnt = encl_pkg::RST_CYC_4;
               s_nxt.st = encl_pkg::ST_RESET;
            end
            else if (wr_ctl && wdata_i[encl_pkg::TM_BIT])
            begin
               s_nxt.tx_cmd = 1'b1; // see RULE_08
               s_nxt.tx_start = 1'b1;
               s_nxt.st = encl_pkg::ST_TX;
            end
         end
         encl_pkg::ST_RESET:
         begin
            // no command is taken while the reset runs
            if (s_r.cnt == 4'h1)
            begin
               s_nxt.rst_cmd = 1'b0; // see RULE_07
               s_nxt.st = encl_pkg::ST_IDLE;
               ev[encl_pkg::IRQ_RSTDONE] = 1'b1;
            end
            s_nxt.cnt = s_r.cnt - 4'h1;
         end
         encl_pkg::ST_TX:
         begin
            if (wr_ctl && wdata_i[encl_pkg::RST_BIT])
            begin
               // reset aborts the message in flight
               s_nxt.rst_cmd = 1'b1; // see RULE_06
               s_nxt.tx_cmd = 1'b0;
               s_nxt.cnt = encl_pkg::RST_CYC_4;
               s_nxt.st = encl_pkg::ST_RESET;
            end
            else if (tx_done_i)
            begin
               s_nxt.tx_cmd = 1'b0; // see RULE_09
               s_nxt.st = encl_pkg::ST_IDLE;
               ev[encl_pkg::IRQ_TXDONE] = 1'b1;
            end
         end
         default:
            s_nxt.st = encl_pkg::ST_IDLE;
      endcase
      // received flag: set wins over a same-cycle clear
      if (wr_ctl && wdata_i[encl_pkg::MR_BIT])
         s_nxt.mr = 1'b0; // see RULE_12
      if (rx_done_i && s_r.st != encl_pkg::ST_RESET)
      begin
         s_nxt.mr = 1'b1; // see RULE_11
         ev[encl_pkg::IRQ_MR] = 1'b1;
      end
      if (s_nxt.st == encl_pkg::ST_RESET)
         s_nxt.mr = 1'b0;
      if (wr_sts)
         s_nxt.sts = s_r.sts & ~wdata_i[encl_pkg::IRQ_N-1:0];
      s_nxt.sts = s_nxt.sts | ev;
      if (wr_msk)
         s_nxt.msk = wdata_i[encl_pkg::IRQ_N-1:0];
      s_nxt.irq = |(s_nxt.sts & s_nxt.msk);
      s_nxt.encl_rst = (s_nxt.st == encl_pkg::ST_RESET);
      s_nxt.rdata = encl_pkg::ZERO32;
      if (rd_i)
      begin
         unique case (addr_i)
            encl_pkg::ENCLOSURE_MSG_CONTROL_STATUS_OFS: s_nxt.rdata = ctl_word(s_r, caps);
            encl_pkg::EXTENDED_CAPABILITIES_OFS: s_nxt.rdata = extended_capabilities_word(caps);
            encl_pkg::INT_STS_OFS: s_nxt.rdata[encl_pkg::IRQ_N-1:0] = s_r.sts;
            encl_pkg::INT_MSK_OFS: s_nxt.rdata[encl_pkg::IRQ_N-1:0] = s_r.msk;
            encl_pkg::LINK_OFS:
            begin
               s_nxt.rdata[encl_pkg::LNK_RST_BIT] = s_r.encl_rst;
               s_nxt.rdata[encl_pkg::LNK_TX_BIT] = s_r.st == encl_pkg::ST_TX;
               s_nxt.rdata[encl_pkg::LNK_RX_BIT] = s_r.mr;
            end
            default: s_nxt.rdata = encl_pkg::ZERO32;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         s_r <= '{st: encl_pkg::ST_IDLE, default: '0};
      else
         s_r <= s_nxt;
   end

   assign rdata_o = s_r.rdata;
   assign irq_o = s_r.irq;
   assign encl_rst_o = s_r.encl_rst;
   assign tx_start_o = s_r.tx_start;

   ////////////////////////////////////////////////////////////////////////////
   property p_rst_set;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (wr_ctl && wdata_i[encl_pkg::RST_BIT] && s_r.st != encl_pkg::ST_RESET)
         |=> s_r.rst_cmd && encl_rst_o;
   endproperty
   a_rst_set: assert property (p_rst_set) // see RULE_06
      else $error("reset command not taken");

   // checker helper: cycles the reset command has stood so far
   logic [3:0] rst_len_r;
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rst_len_r <= 4'h0;
      else if (s_r.rst_cmd)
         rst_len_r <= rst_len_r + 4'h1;
      else
         rst_len_r <= 4'h0;
   end

   property p_rst_clear;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      $fell(s_r.rst_cmd) |-> rst_len_r == encl_pkg::RST_CYC_4;
   endproperty
   a_rst_clear: assert property (p_rst_clear) // see RULE_07
      else $error("reset command length wrong");

   property p_tx_start;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (wr_ctl && wdata_i[encl_pkg::TM_BIT] && !wdata_i[encl_pkg::RST_BIT]
         && s_r.st == encl_pkg::ST_IDLE) |=> tx_start_o && s_r.tx_cmd;
   endproperty
   a_tx_start: assert property (p_tx_start) // see RULE_08
      else $error("transmit not started");

   property p_tx_done;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (s_r.st == encl_pkg::ST_TX && tx_done_i && !wr_ctl) |=> !s_r.tx_cmd;
   endproperty
   a_tx_done: assert property (p_tx_done) // see RULE_09
      else $error("transmit bit not cleared");

   property p_tx_hold;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (s_r.tx_cmd && !tx_done_i && !wr_ctl) |=> s_r.tx_cmd;
   endproperty
   a_tx_hold: assert property (p_tx_hold) // see RULE_09
      else $error("transmit bit dropped early");

   property p_mr_set;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (rx_done_i && s_r.st != encl_pkg::ST_RESET && !wr_ctl) |=> s_r.mr
         ##1 (s_r.sts[encl_pkg::IRQ_MR] || $past(wr_sts));
   endproperty
   a_mr_set: assert property (p_mr_set) // see RULE_11
      else $error("received flag not set");

   property p_mr_w0;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (s_r.mr && wr_ctl && !wdata_i[encl_pkg::MR_BIT]
         && !wdata_i[encl_pkg::RST_BIT]) |=> s_r.mr;
   endproperty
   a_mr_w0: assert property (p_mr_w0) // see RULE_12
      else $error("received flag lost on write 0");

   property p_cap_read;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (rd_i && addr_i == encl_pkg::EXTENDED_CAPABILITIES_OFS) |=>
         rdata_o == {29'h0, AUTO_PARTIAL_TO_SLUMBER_CAP, NV_CACHE_SUPPORT_CAP, OWNERSHIP_HANDOFF_CAP};
   endproperty
   a_cap_read: assert property (p_cap_read) // see RULE_15
      else $error("extended capability read wrong");

   property p_ctl_resv;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (rd_i && addr_i == encl_pkg::ENCLOSURE_MSG_CONTROL_STATUS_OFS) |=>
         rdata_o[31:25] == 7'h0 && rdata_o[23:20] == 4'h0
         && rdata_o[15:10] == 6'h0 && rdata_o[7:1] == 7'h0
         && rdata_o[24] == SMB && rdata_o[19:16] == {SGPIO, SES2, SAFTE, LED};
   endproperty
   a_ctl_resv: assert property (p_ctl_resv) // see RULE_17
      else $error("control read wrong");

   property p_irq;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      ##1 irq_o == |($past(s_nxt.sts) & $past(s_nxt.msk));
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt level wrong");
endmodule

// ### encl_partner.sv
`timescale 1ns/10ps
// far-side transmit engine and receive source
module encl_partner (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic tx_start_i,
   input wire logic encl_rst_i,
   input wire logic [4:0] dly_i,
   input wire logic rx_req_i,
   output logic tx_done_o,
   output logic rx_done_o
);
   logic busy_r;
   logic [4:0] cnt_r;
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         busy_r <= 1'b0;
         cnt_r <= 5'h00;
         tx_done_o <= 1'b0;
         rx_done_o <= 1'b0;
      end
      else
      begin
         tx_done_o <= 1'b0;
         rx_done_o <= rx_req_i;
         // done only after a start; a reset aborts the message
         if (encl_rst_i)
            busy_r <= 1'b0;
         else if (tx_start_i)
         begin
            busy_r <= 1'b1;
            cnt_r <= dly_i;
         end
         else if (busy_r && cnt_r == 5'h00)
         begin
            busy_r <= 1'b0;
            tx_done_o <= 1'b1;
         end
         else if (busy_r)
            cnt_r <= cnt_r - 5'h01;
      end
   end
endmodule

// ### enclosure_mgmt_control_caps_tb.sv
`timescale 1ns/10ps
module enclosure_mgmt_control_caps_tb;
   localparam logic [31:0] CAPS = 32'h0105_0000;
   localparam logic [31:0] EXTENDED_CAPABILITIES = 32'h0000_0005;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rx_req = 1'b0;
   logic [4:0] dly = 5'h00;
   logic [31:0] rdata, v;
   logic irq, encl_rst, tx_start, tx_done, rx_done;
   int err_count = 0;
   int checks = 0;
   int seed = 32'ha247;
   int n;
   always #50 clk = ~clk;
   enclosure_mgmt_control_caps #(.SMB(1'b1), .SES2(1'b1), .AUTO_PARTIAL_TO_SLUMBER_CAP(1'b1),
      .OWNERSHIP_HANDOFF_CAP(1'b1)) u_dut (.core_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq),
      .encl_rst_o(encl_rst), .tx_start_o(tx_start), .tx_done_i(tx_done),
      .rx_done_i(rx_done));
   encl_partner u_far (.clk_i(clk), .rst_n_i(rst_n), .tx_start_i(tx_start),
      .encl_rst_i(encl_rst), .dly_i(dly), .rx_req_i(rx_req),
      .tx_done_o(tx_done), .rx_done_o(rx_done));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] got, exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, string nm);
      logic [31:0] d;
      rd_reg(a, d);
      chk(nm, d, e);
   endtask
   task automatic rx_msg;
      @(posedge clk);
      rx_req <= 1'b1;
      @(posedge clk);
      rx_req <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      #2000000;
      err_count++;
      end_sim();
   end
   initial
   begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rdc(8'h20, CAPS, "ctl");
      rdc(8'h24, EXTENDED_CAPABILITIES, "extended_capabilities");
      rdc(8'h40, 32'h0000_0000, "unmapped");
      // reserved bits and bit 24 hammered with ones; read-only bits 19:16 written with zeros
      wr_reg(8'h24, 32'hffff_ffff);
      wr_reg(8'h20, 32'hfff0_fcfe);
      rdc(8'h20, CAPS, "ctl ro");
      rdc(8'h24, EXTENDED_CAPABILITIES, "extended_capabilities ro");
      $display("caps test done");
      for (int i = 0; i < 4; i++)
      begin
         dly <= 5'h08 + 5'($random(seed) & 15);
         wr_reg(8'h20, 32'h0000_0100);
         // a zero write must not cancel a message in flight
         wr_reg(8'h20, 32'h0000_0000);
         rdc(8'h20, CAPS | 32'h0000_0100, "transmit_cmd");
         n = 0;
         do
         begin
            rd_reg(8'h20, v);
            n++;
         end
         while (v[8] !== 1'b0 && n < 40);
         chk("transmit_cmd clear", v, CAPS);
         rdc(8'h30, 32'h0000_0002, "sts tx");
         wr_reg(8'h30, 32'h0000_0002);
      end
      $display("transmit test done");
      wr_reg(8'h20, 32'h0000_0200);
      n = 0;
      repeat (14)
      begin
         #1 n = n + int'(encl_rst === 1'b1);
         @(posedge clk);
      end
      chk("rst len", 32'(n), 32'(encl_pkg::RST_CYC));
      rdc(8'h20, CAPS, "enclosure_reset_cmd clear");
      rdc(8'h30, 32'h0000_0004, "sts rst");
      wr_reg(8'h30, 32'h0000_0004);
      $display("reset test done");
      rx_msg();
      rdc(8'h20, CAPS | 32'h0000_0001, "ctl mr");
      wr_reg(8'h20, 32'h0000_0000);
      rdc(8'h20, CAPS | 32'h0000_0001, "ctl mr w0");
      wr_reg(8'h34, 32'h0000_0001);
      rdc(8'h30, 32'h0000_0001, "message_received_flag");
      chk("irq on", {31'h0, irq}, 32'h0000_0001);
      wr_reg(8'h30, 32'h0000_0001);
      rdc(8'h30, 32'h0000_0000, "sts clr");
      chk("irq off", {31'h0, irq}, 32'h0000_0000);
      wr_reg(8'h34, 32'h0000_0000);
      // reset while a message waits drops it
      wr_reg(8'h20, 32'h0000_0200);
      rdc(8'h20, CAPS | 32'h0000_0200, "enclosure_reset_cmd run");
      rdc(8'h38, 32'h0000_0001, "link rst");
      repeat (12) @(posedge clk);
      rdc(8'h20, CAPS, "ctl after rst");
      wr_reg(8'h30, 32'h0000_0004);
      rx_msg();
      // software reads the message before clearing
      rdc(8'h20, CAPS | 32'h0000_0001, "ctl mr 2");
      wr_reg(8'h20, 32'h0000_0001);
      rdc(8'h20, CAPS, "ctl mr w1c");
      $display("receive test done");
      end_sim();
   end
endmodule
